// ### ocmd_pkg.sv
// Shared constants, enumerations and carrier structs of the output clock mux and divider block
package ocmd_pkg;

    localparam int NUM_OUT      = 14;
    localparam int NUM_DIV      = 9;
    localparam int NUM_REF      = 4;
    localparam int NUM_GPIO     = 2;
    localparam int NUM_SRC      = 9;
    localparam int CD_W         = 12;
    localparam int SD_W         = 20;
    localparam int FIRST_PAIR   = 4;

    localparam logic [7:0] PULSE_REQUEST_CONTROL_OFS        = 8'h1a;
    localparam logic [7:0] REFERENCE_PASSTHROUGH_SELECT_OFS = 8'h30;
    localparam logic [7:0] PULSE_REQUEST_CONTROL_RST        = 8'h00;
    localparam logic [7:0] REFERENCE_PASSTHROUGH_SELECT_RST = 8'h00;

    localparam int REQ_MODE_LSB = 4;
    localparam int REQ_SEL_LSB  = 2;
    localparam int REQ_STAT_BIT = 0;
    localparam int REF_SEL_LSB  = 0;
    localparam int REF_SEL_W    = 5;

    localparam logic [1:0] REQ_MODE_CONTINUOUS = 2'h0;
    localparam logic [1:0] REQ_MODE_RESAMPLE   = 2'h3;

    typedef enum logic [2:0] {
        SRC_BAW, SRC_APLL2, SRC_APLL1_PRI, SRC_APLL1_SEC, SRC_XO, SRC_REF
    } ocmd_src_e;

    typedef enum logic [2:0] {
        PATH_BYPASS, PATH_CHANNEL_DIVIDER_PATH, PATH_HALF, PATH_PULSE, PATH_PULSE_ANALOG_DELAY_PATH, PATH_STATIC
    } ocmd_path_e;

    typedef struct packed {
        logic [NUM_REF-1:0] reference_input_source;
        logic               crystal_clock_source;
        logic               apll1_sec;
        logic               apll1_pri;
        logic               apll2;
        logic               baw;
    } ocmd_clk_src_s;

    typedef struct packed {
        ocmd_path_e path;
        logic       output_driver_enable;
    } ocmd_chan_cfg_s;

    typedef struct packed {
        ocmd_src_e         src_sel;
        logic [CD_W-1:0]   channel_divide_value;
        logic [SD_W-1:0]   pulse_divide_value;
        logic              pulse_replica_to_pin_enable;
    } ocmd_div_cfg_s;

    typedef struct packed {
        logic true_output_leg;
        logic complement_output_leg;
        logic oe_n;
    } ocmd_leg_s;

endpackage : ocmd_pkg

// ### ocmd_top.sv
// Output source selectors, path selectors, channel and pulse dividers, pin replica
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Outputs 0 and 1 each pick any post-divider, crystal or reference clock.
// - Outputs 2 and 3 each pick resonator, second PLL or first PLL primary.
// - Pairs from output 4 share one selector: resonator or second PLL.
// - Reference passes only when enabled; one-hot field picks reference 0 to 3.
// - Path choices: bypass, channel divider, halve, pulse, pulse with delay, static.
// - Static path holds true leg low and complement leg high.
// - Cleared driver enable puts the output in high impedance.
// - Outputs 2 and 3 have own 12-bit divider and no pulse divider.
// - Each pair from output 4 has 12-bit divider plus optional 20-bit one.
// - Outputs 0 and 1 each have 12-bit divider and 20-bit pulse divider.
// - Total division is post-divider times channel value times pulse value.
// - A pair divider powers down when both drivers of the pair are off.
// - Dividers of outputs 0 and 1 power down with their driver.
// - Pulse dividers reach rates from one per second to 25 MHz.
// - Pin replica driven only if pin enabled and an active divider replicates.
// - Replica is tapped before analog delay, further delay and pulser.
// - Replica is always continuous; pulsed gating never applies to it.
// - Sync release lets all dividers restart on the same source edge.
module ocmd_top
    import ocmd_pkg::*;
(
    input  wire logic                     mclk,
    input  wire logic                     nrst,
    input  wire ocmd_clk_src_s            src_in,
    input  wire logic                     sync_in,
    input  wire logic                     pulse_request_in,
    input  wire logic                     reference_passthrough_enable,
    input  wire ocmd_chan_cfg_s [NUM_OUT-1:0] chan_cfg,
    input  wire ocmd_div_cfg_s  [NUM_DIV-1:0] div_cfg,
    input  wire logic [NUM_GPIO-1:0]      general_pin_output_enable,
    input  wire logic [7:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    output logic [7:0]                    reg_rdata,
    output ocmd_leg_s [NUM_OUT-1:0]       out_leg,
    output logic [NUM_GPIO-1:0]           gpio_out,
    output logic [NUM_GPIO-1:0]           gpio_oe_n
);

    // Source-selection helper: one function covers every selector width
    function automatic logic src_pick(input int unsigned d, input ocmd_src_e sel,
                                      input ocmd_clk_src_s s, input logic ref_lvl);
        logic v;
        v = 1'b0;
        unique case (sel)
            SRC_BAW:       v = s.baw;
            SRC_APLL2:     v = s.apll2;
            SRC_APLL1_PRI: v = (d < FIRST_PAIR) ? s.apll1_pri : 1'b0;
            SRC_APLL1_SEC: v = (d < 2) ? s.apll1_sec : 1'b0;
            SRC_XO:        v = (d < 2) ? s.crystal_clock_source : 1'b0;
            SRC_REF:       v = (d < 2) ? ref_lvl : 1'b0;
            default:       v = 1'b0;
        endcase
        return v;
    endfunction : src_pick

    // Next count of a modulo-n divider; n of 0 or 1 divides by one
    function automatic logic [SD_W-1:0] cnt_next(input logic [SD_W-1:0] cnt,
                                                 input logic [SD_W-1:0] n);
        logic [SD_W-1:0] r;
        r = '0;
        if (n > 20'h00001 && cnt < n - 20'h00001) begin
            r = cnt + 20'h00001;
        end
        return r;
    endfunction : cnt_next

    // High for the first half of the divider period, rounded up
    function automatic logic hi_phase(input logic [SD_W-1:0] cnt,
                                      input logic [SD_W-1:0] n);
        logic [SD_W:0] half;
        half = ({1'b0, n} + 21'h000001) >> 1;
        return {1'b0, cnt} < half;
    endfunction : hi_phase

    function automatic int unsigned out_div(input int unsigned o);
        return (o < FIRST_PAIR) ? o : FIRST_PAIR + (o - FIRST_PAIR) / 2;
    endfunction : out_div

    // Two-stage synchronisers for sources, sync and request pins
    localparam int IN_W = NUM_SRC + 2;
    logic [IN_W-1:0] in_meta_q;
    logic [IN_W-1:0] in_sync_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            in_meta_q <= '0;
            in_sync_q <= '0;
        end else begin
            in_meta_q <= {pulse_request_in, sync_in, src_in};
            in_sync_q <= in_meta_q;
        end
    end

    ocmd_clk_src_s src_s;
    wire logic     sync_s = in_sync_q[NUM_SRC];
    wire logic     req_s  = in_sync_q[NUM_SRC+1];
    assign src_s = ocmd_clk_src_s'(in_sync_q[NUM_SRC-1:0]);

    // Host registers
    logic [7:0] pulse_request_control_q;
    logic [7:0] reference_passthrough_select_q;
    logic [7:0] reg_rdata_q;
    logic       req_eff;

    wire logic wr_ctrl = reg_wr && reg_addr == PULSE_REQUEST_CONTROL_OFS;
    wire logic wr_ref  = reg_wr && reg_addr == REFERENCE_PASSTHROUGH_SELECT_OFS;
    wire logic [1:0] pulse_request_resample_mode =
        pulse_request_control_q[REQ_MODE_LSB +: 2];
    wire logic [1:0] pulse_request_sample_select =
        pulse_request_control_q[REQ_SEL_LSB +: 2];
    wire logic [REF_SEL_W-1:0] ref_sel =
        reference_passthrough_select_q[REF_SEL_LSB +: REF_SEL_W];

    // Only the documented fields are stored; the rest read as zero, except the request status at bit 0
    wire logic [7:0] ctrl_mask = 8'h3c;
    wire logic [7:0] ref_mask  = 8'h1f;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pulse_request_control_q        <= PULSE_REQUEST_CONTROL_RST;
            reference_passthrough_select_q <= REFERENCE_PASSTHROUGH_SELECT_RST;
        end else begin
            if (wr_ctrl) begin
                pulse_request_control_q <= reg_wdata & ctrl_mask;
            end
            if (wr_ref) begin
                reference_passthrough_select_q <= reg_wdata & ref_mask;
            end
        end
    end

    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr == PULSE_REQUEST_CONTROL_OFS) begin
            rd_mux = pulse_request_control_q;
            rd_mux[REQ_STAT_BIT] = req_eff;
        end else if (reg_addr == REFERENCE_PASSTHROUGH_SELECT_OFS) begin
            rd_mux = reference_passthrough_select_q;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_q <= 8'h00;
        end else begin
            reg_rdata_q <= rd_mux;
        end
    end
    assign reg_rdata = reg_rdata_q;

    // Reference pass-through; a field that is not one-hot passes nothing
    wire logic ref_onehot = !ref_sel[NUM_REF] && $onehot(ref_sel[NUM_REF-1:0]);
    wire logic ref_lvl = reference_passthrough_enable && ref_onehot &&
                         |(ref_sel[NUM_REF-1:0] & src_s.reference_input_source);

    // Pulse request: direct, or re-timed on the selected source edge
    logic [3:0] samp_src;
    logic       samp_prev_q;
    logic       req_rs_q;
    assign samp_src = {src_s.apll1_sec, src_s.apll1_pri, src_s.apll2, src_s.baw};
    wire logic samp_lvl  = samp_src[pulse_request_sample_select];
    wire logic samp_rise = samp_lvl && !samp_prev_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            samp_prev_q <= 1'b0;
            req_rs_q    <= 1'b0;
        end else begin
            samp_prev_q <= samp_lvl;
            if (samp_rise) begin
                req_rs_q <= req_s;
            end
        end
    end

    // Continuous mode ignores the request pin so a bare board still gets pulses
    assign req_eff = (pulse_request_resample_mode == REQ_MODE_CONTINUOUS) ? 1'b1 :
                     (pulse_request_resample_mode == REQ_MODE_RESAMPLE) ? req_rs_q :
                     req_s;

    // Divider units: 0,1 full channels; 2,3 channel-only; 4..8 shared pairs
    logic [NUM_DIV-1:0] sel_lvl;
    logic [NUM_DIV-1:0] cd_lvl;
    logic [NUM_DIV-1:0] half_lvl;
    logic [NUM_DIV-1:0] sd_lvl;
    logic [NUM_DIV-1:0] div_on;

    for (genvar d = 0; d < NUM_DIV; d++) begin : g_div
        logic [CD_W-1:0] cd_cnt_q;
        logic [SD_W-1:0] sd_cnt_q;
        logic            cd_q;
        logic            sd_q;
        logic            half_q;
        logic            src_prev_q;
        logic            cd_prev_q;
        logic            pd;
        logic [SD_W-1:0] cd_n;
        logic [SD_W-1:0] cd_nx;

        assign sel_lvl[d] = src_pick(d, div_cfg[d].src_sel, src_s, ref_lvl);

        if (d < 2) begin : g_single
            assign pd = !chan_cfg[d].output_driver_enable;
        end else if (d < FIRST_PAIR) begin : g_mid
            assign pd = !chan_cfg[d].output_driver_enable;
        end else begin : g_pair
            assign pd = !(chan_cfg[2*d-FIRST_PAIR].output_driver_enable ||
                          chan_cfg[2*d-FIRST_PAIR+1].output_driver_enable);
        end

        assign div_on[d] = !pd;
        assign cd_n  = {{(SD_W-CD_W){1'b0}}, div_cfg[d].channel_divide_value};
        assign cd_nx = cnt_next({{(SD_W-CD_W){1'b0}}, cd_cnt_q}, cd_n);
        wire logic src_rise = sel_lvl[d] && !src_prev_q;
        // Divide-by-one passes the selected source straight through
        assign cd_lvl[d] = (cd_n <= 20'h00001) ? sel_lvl[d] : cd_q;
        wire logic cd_rise = cd_lvl[d] && !cd_prev_q;
        wire logic [SD_W-1:0] sd_nx = cnt_next(sd_cnt_q, div_cfg[d].pulse_divide_value);
        wire logic sd_one = div_cfg[d].pulse_divide_value <= 20'h00001;

        // Power-down and sync share one clear, so a pair restarts aligned
        always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                src_prev_q <= 1'b0;
                cd_prev_q  <= 1'b0;
                cd_cnt_q   <= '0;
                cd_q       <= 1'b0;
                half_q     <= 1'b0;
                sd_cnt_q   <= '0;
                sd_q       <= 1'b0;
            end else begin
                src_prev_q <= sel_lvl[d];
                cd_prev_q  <= cd_lvl[d];
                if (pd || sync_s) begin
                    cd_cnt_q <= '0;
                    cd_q     <= 1'b0;
                    half_q   <= 1'b0;
                    sd_cnt_q <= '0;
                    sd_q     <= 1'b0;
                end else begin
                    if (src_rise) begin
                        cd_cnt_q <= cd_nx[CD_W-1:0];
                        cd_q     <= hi_phase(cd_nx, cd_n);
                        half_q   <= !half_q;
                    end
                    if (cd_rise) begin
                        sd_cnt_q <= sd_nx;
                        sd_q     <= hi_phase(sd_nx, div_cfg[d].pulse_divide_value);
                    end
                end
            end
        end

        assign half_lvl[d] = half_q;
        if (d < 2 || d >= FIRST_PAIR) begin : g_sd
            assign sd_lvl[d] = sd_one ? cd_lvl[d] : sd_q;
        end else begin : g_nosd
            assign sd_lvl[d] = 1'b0;
        end
    end

    // Per-output path selectors and driver state
    for (genvar o = 0; o < NUM_OUT; o++) begin : g_out
        localparam int unsigned D = out_div(o);
        logic      lvl;
        ocmd_leg_s leg_q;

        always_comb begin
            lvl = 1'b0;
            unique case (chan_cfg[o].path)
                PATH_BYPASS:     lvl = sel_lvl[D];
                PATH_CHANNEL_DIVIDER_PATH:      lvl = cd_lvl[D];
                PATH_HALF:       lvl = half_lvl[D];
                PATH_PULSE:      lvl = sd_lvl[D] && req_eff;
                // Analog delay lives in the driver; logically the same pulse
                PATH_PULSE_ANALOG_DELAY_PATH: lvl = sd_lvl[D] && req_eff;
                PATH_STATIC:     lvl = 1'b0;
                default:         lvl = 1'b0;
            endcase
        end

        always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                leg_q <= '{true_output_leg: 1'b0, complement_output_leg: 1'b0, oe_n: 1'b1};
            end else if (!chan_cfg[o].output_driver_enable) begin
                leg_q <= '{true_output_leg: 1'b0, complement_output_leg: 1'b0,
                           oe_n: 1'b1};
            end else begin
                leg_q <= '{true_output_leg: lvl, complement_output_leg: !lvl,
                           oe_n: 1'b0};
            end
        end
        assign out_leg[o] = leg_q;
    end

    // Pin replica: continuous divider output, never gated by the request
    logic [NUM_DIV-1:0] rep_src;
    for (genvar d = 0; d < NUM_DIV; d++) begin : g_rep
        if (d < 2 || d >= FIRST_PAIR) begin : g_yes
            assign rep_src[d] = div_on[d] && div_cfg[d].pulse_replica_to_pin_enable;
        end else begin : g_no
            assign rep_src[d] = 1'b0;
        end
    end

    wire logic rep_any = |rep_src;
    wire logic rep_lvl = |(rep_src & sd_lvl);

    logic [NUM_GPIO-1:0] gpio_q;
    logic [NUM_GPIO-1:0] gpio_oe_n_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            gpio_q      <= '0;
            gpio_oe_n_q <= '1;
        end else begin
            gpio_q      <= general_pin_output_enable & {NUM_GPIO{rep_any && rep_lvl}};
            gpio_oe_n_q <= ~(general_pin_output_enable & {NUM_GPIO{rep_any}});
        end
    end
    assign gpio_out  = gpio_q;
    assign gpio_oe_n = gpio_oe_n_q;

endmodule : ocmd_top
`default_nettype wire

// ### ocmd_top_chk_sva.sv
// Port-level assertions for the output clock mux and divider block
`timescale 1ns/10ps
`default_nettype none
module ocmd_top_chk
    import ocmd_pkg::*;
(
    input wire logic                         mclk,
    input wire logic                         nrst,
    input wire ocmd_chan_cfg_s [NUM_OUT-1:0] chan_cfg,
    input wire ocmd_div_cfg_s  [NUM_DIV-1:0] div_cfg,
    input wire logic [NUM_GPIO-1:0]          general_pin_output_enable,
    input wire logic [7:0]                   reg_addr,
    input wire logic [7:0]                   reg_wdata,
    input wire logic                         reg_wr,
    input wire logic [7:0]                   reg_rdata,
    input wire ocmd_leg_s [NUM_OUT-1:0]      out_leg,
    input wire logic [NUM_GPIO-1:0]          gpio_oe_n
);
    logic [NUM_OUT-1:0] off_cfg, hiz_out, stat_cfg, stat_out;
    logic               rep_any;

    // A divider only replicates while one of its drivers keeps it powered
    always_comb begin
        rep_any = 1'b0;
        for (int k = 0; k < NUM_OUT; k++) begin
            off_cfg[k]  = !chan_cfg[k].output_driver_enable;
            hiz_out[k]  = out_leg[k].oe_n && !out_leg[k].true_output_leg
                          && !out_leg[k].complement_output_leg;
            stat_cfg[k] = chan_cfg[k].output_driver_enable && chan_cfg[k].path == PATH_STATIC;
            stat_out[k] = !out_leg[k].oe_n && !out_leg[k].true_output_leg
                          && out_leg[k].complement_output_leg;
        end
        for (int d = 0; d < NUM_DIV; d++) begin
            if ((d < 2 && chan_cfg[d].output_driver_enable) || (d >= FIRST_PAIR
                && (chan_cfg[2*d-4].output_driver_enable || chan_cfg[2*d-3].output_driver_enable)))
                rep_any = rep_any | div_cfg[d].pulse_replica_to_pin_enable;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    property p_off_hiz;
        1'b1 |=> ((hiz_out & $past(off_cfg)) == $past(off_cfg));
    endproperty
    a_off_hiz: assert property (p_off_hiz) else $error("disabled output not high impedance");
    property p_static;
        (|stat_cfg) |=> ((stat_out & $past(stat_cfg)) == $past(stat_cfg));
    endproperty
    a_static: assert property (p_static) else $error("static path legs wrong");
    property p_unmapped;
        (reg_addr != PULSE_REQUEST_CONTROL_OFS && reg_addr != REFERENCE_PASSTHROUGH_SELECT_OFS)
            |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped address read nonzero");
    property p_ref_rsvd;
        reg_addr == REFERENCE_PASSTHROUGH_SELECT_OFS |=> reg_rdata[7:5] == 3'h0;
    endproperty
    a_ref_rsvd: assert property (p_ref_rsvd) else $error("reference select spare bits set");
    property p_ref_wr;
        (reg_wr && reg_addr == REFERENCE_PASSTHROUGH_SELECT_OFS) ##1
            (reg_addr == REFERENCE_PASSTHROUGH_SELECT_OFS) |=> reg_rdata[4:0] == $past(reg_wdata[4:0], 2);
    endproperty
    a_ref_wr: assert property (p_ref_wr) else $error("reference select not stored");
    property p_req_rsvd;
        reg_addr == PULSE_REQUEST_CONTROL_OFS |=> reg_rdata[7:6] == 2'h0 && reg_rdata[1] == 1'b0;
    endproperty
    a_req_rsvd: assert property (p_req_rsvd) else $error("request control spare bits set");
    property p_req_wr;
        (reg_wr && reg_addr == PULSE_REQUEST_CONTROL_OFS) ##1
            (reg_addr == PULSE_REQUEST_CONTROL_OFS) |=> reg_rdata[5:2] == $past(reg_wdata[5:2], 2);
    endproperty
    a_req_wr: assert property (p_req_wr) else $error("request control not stored");
    property p_gpio_oe;
        1'b1 |=> gpio_oe_n == ~($past(general_pin_output_enable) & {NUM_GPIO{$past(rep_any)}});
    endproperty
    a_gpio_oe: assert property (p_gpio_oe) else $error("pin replica enable wrong");
    property p_no_pulse2;
        (chan_cfg[2].output_driver_enable && (chan_cfg[2].path == PATH_PULSE
            || chan_cfg[2].path == PATH_PULSE_ANALOG_DELAY_PATH)) |=> !out_leg[2].true_output_leg;
    endproperty
    a_no_pulse2: assert property (p_no_pulse2) else $error("pulse path active on output 2");
endmodule : ocmd_top_chk

bind ocmd_top ocmd_top_chk i_ocmd_top_chk (
    .mclk(mclk), .nrst(nrst), .chan_cfg(chan_cfg), .div_cfg(div_cfg),
    .general_pin_output_enable(general_pin_output_enable), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .out_leg(out_leg),
    .gpio_oe_n(gpio_oe_n));
`default_nettype wire

// ### ocmd_rx_model.sv
// Downstream clock receiver model that counts rising edges of one output
`timescale 1ns/10ps
`default_nettype none
module ocmd_rx_model
    import ocmd_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      nrst,
    input  wire ocmd_leg_s leg,
    input  wire logic      clr,
    output logic [15:0]    edges
);
    logic prev_q;

    // A high-impedance leg carries nothing, so only driven edges count
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prev_q <= 1'b0;
            edges  <= 16'h0000;
        end else begin
            prev_q <= leg.true_output_leg;
            if (clr)
                edges <= 16'h0000;
            else if (!leg.oe_n && leg.true_output_leg && !prev_q)
                edges <= edges + 16'h0001;
        end
    end
endmodule : ocmd_rx_model
`default_nettype wire

// ### ocmd_tb_top.sv
// Self-checking testbench of the output clock mux and divider block
`timescale 1ns/10ps
`default_nettype none
module ocmd_tb_top
    import ocmd_pkg::*;
;
    logic                         mclk, nrst, sync_in, pulse_request_in, ref_en, reg_wr, clr;
    ocmd_clk_src_s                src_in;
    ocmd_chan_cfg_s [NUM_OUT-1:0] chan_cfg;
    ocmd_div_cfg_s  [NUM_DIV-1:0] div_cfg;
    logic [NUM_GPIO-1:0]          gpio_en, gpio_out, gpio_oe_n;
    logic [7:0]                   reg_addr, reg_wdata, reg_rdata, rd_q;
    ocmd_leg_s [NUM_OUT-1:0]      out_leg;
    ocmd_leg_s                    watch;
    logic [15:0]                  edges;
    logic [7:0]                   scnt = 8'h00;
    int                           wsel, n_fail, n_checks;

    // Source periods of 8 and 16 cycles stay well under half the system clock
    assign src_in = {scnt[2], scnt[2], scnt[2], scnt[3], scnt[2], scnt[3], scnt[2], scnt[3], scnt[2]};
    assign watch  = out_leg[wsel];

    ocmd_top i_ocmd_top (.mclk(mclk), .nrst(nrst), .src_in(src_in), .sync_in(sync_in),
        .pulse_request_in(pulse_request_in), .reference_passthrough_enable(ref_en),
        .chan_cfg(chan_cfg), .div_cfg(div_cfg), .general_pin_output_enable(gpio_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
        .out_leg(out_leg), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n));
    ocmd_rx_model i_ocmd_rx_model (.mclk(mclk), .nrst(nrst), .leg(watch), .clr(clr), .edges(edges));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(negedge mclk) scnt <= scnt + 8'h01;

    task automatic tally_and_finish();
        if (n_fail == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        // Let one edge pass so a following write never re-raises the strobe at once
        @(negedge mclk);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        reg_addr = a;
        @(negedge mclk);
        rd_q = reg_rdata;
    endtask : rd

    // Edge count of one output over 96 cycles, i.e. 12 fast or 6 slow source edges
    task automatic rate(input int o, input ocmd_path_e p, input ocmd_src_e s, input int cd,
                        input int sd, input int exp);
        int d;
        int g;
        d = (o < FIRST_PAIR) ? o : FIRST_PAIR + (o - FIRST_PAIR) / 2;
        chan_cfg = '0;
        div_cfg[d].src_sel = s;
        div_cfg[d].channel_divide_value = CD_W'(cd);
        div_cfg[d].pulse_divide_value = SD_W'(sd);
        chan_cfg[o] = '{p, 1'b1};
        wsel = o;
        repeat (16) @(negedge mclk);
        clr = 1'b1;
        @(negedge mclk);
        clr = 1'b0;
        repeat (96) @(negedge mclk);
        g = int'(edges);
        chk("edge_count", exp, ((exp == 0) ? g == 0 : (g <= exp + 1 && g + 1 >= exp)) ? exp : g);
    endtask : rate

    task automatic t_reset();
        chk("leg0_reset", 3'b001, out_leg[0]);
        rd(REFERENCE_PASSTHROUGH_SELECT_OFS);
        chk("ref_sel_reset", REFERENCE_PASSTHROUGH_SELECT_RST, rd_q);
    endtask : t_reset

    task automatic t_regs();
        wr(8'h30, 8'hff);
        rd(8'h30);
        chk("ref_sel", 8'h1f, rd_q);
        wr(8'h1a, 8'hff);
        rd(8'h1a);
        chk("req_ctl", 8'h3c, rd_q & 8'hfe);
        wr(8'h77, 8'h5a);
        rd(8'h77);
        chk("unmapped", 8'h00, rd_q);
        wr(8'h30, 8'h01);
        wr(8'h1a, 8'h30);
    endtask : t_regs

    task automatic t_rates();
        rate(0, PATH_BYPASS, SRC_BAW, 1, 1, 12);
        rate(0, PATH_BYPASS, SRC_APLL2, 1, 1, 6);
        rate(0, PATH_BYPASS, SRC_APLL1_PRI, 1, 1, 12);
        rate(0, PATH_BYPASS, SRC_APLL1_SEC, 1, 1, 6);
        rate(0, PATH_BYPASS, SRC_XO, 1, 1, 12);
        rate(0, PATH_BYPASS, SRC_REF, 1, 1, 6);
        ref_en = 1'b0;
        rate(0, PATH_BYPASS, SRC_REF, 1, 1, 0);
        ref_en = 1'b1;
        rate(1, PATH_CHANNEL_DIVIDER_PATH, SRC_BAW, 3, 1, 4);
        rate(1, PATH_HALF, SRC_BAW, 1, 1, 6);
        rate(1, PATH_PULSE, SRC_BAW, 2, 2, 3);
        rate(1, PATH_PULSE_ANALOG_DELAY_PATH, SRC_BAW, 2, 2, 3);
        rate(2, PATH_CHANNEL_DIVIDER_PATH, SRC_APLL1_PRI, 2, 1, 6);
        rate(2, PATH_PULSE, SRC_BAW, 1, 2, 0);
        rate(3, PATH_BYPASS, SRC_XO, 1, 1, 0);
        rate(5, PATH_CHANNEL_DIVIDER_PATH, SRC_APLL2, 2, 1, 3);
        rate(4, PATH_PULSE, SRC_BAW, 2, 3, 2);
        rate(6, PATH_BYPASS, SRC_APLL1_PRI, 1, 1, 0);
    endtask : t_rates

    task automatic t_static();
        chan_cfg = '0;
        chan_cfg[7] = '{PATH_STATIC, 1'b1};
        repeat (3) @(negedge mclk);
        chk("static_leg", 3'b010, out_leg[7]);
        chan_cfg[7].output_driver_enable = 1'b0;
        repeat (3) @(negedge mclk);
        chk("off_leg", 3'b001, out_leg[7]);
    endtask : t_static

    task automatic t_replica();
        int hi;
        div_cfg[4] = '{SRC_BAW, 12'h001, 20'h00002, 1'b1};
        chan_cfg = '0;
        chan_cfg[4].output_driver_enable = 1'b1;
        gpio_en = 2'b11;
        pulse_request_in = 1'b0;
        repeat (4) @(negedge mclk);
        chk("gpio_oe_on", 2'b00, gpio_oe_n);
        hi = 0;
        repeat (64) begin
            @(negedge mclk);
            hi = hi + ((gpio_out[0] === 1'b1) ? 1 : 0);
        end
        chk("gpio_toggles", 1, (hi > 8 && hi < 56) ? 1 : 0);
        chan_cfg[4].output_driver_enable = 1'b0;
        repeat (3) @(negedge mclk);
        chk("pair_off", 2'b11, gpio_oe_n);
        chan_cfg[5].output_driver_enable = 1'b1;
        gpio_en = 2'b01;
        repeat (3) @(negedge mclk);
        chk("one_pin", 2'b10, gpio_oe_n);
        div_cfg[4].pulse_replica_to_pin_enable = 1'b0;
        div_cfg[0].pulse_replica_to_pin_enable = 1'b1;
        repeat (3) @(negedge mclk);
        chk("out0_off", 2'b11, gpio_oe_n);
        rd(PULSE_REQUEST_CONTROL_OFS);
        chk("req_low", 8'h30, rd_q);
        pulse_request_in = 1'b1;
    endtask : t_replica

    task automatic t_sync();
        int bad;
        chan_cfg = '0;
        for (int k = 0; k < 2; k++) begin
            div_cfg[k] = '{SRC_BAW, 12'h003, 20'h00001, 1'b0};
            chan_cfg[k] = '{PATH_CHANNEL_DIVIDER_PATH, 1'b1};
        end
        div_cfg[1].channel_divide_value = 12'h005;
        repeat (20) @(negedge mclk);
        div_cfg[1].channel_divide_value = 12'h003;
        sync_in = 1'b1;
        repeat (4) @(negedge mclk);
        sync_in = 1'b0;
        repeat (10) @(negedge mclk);
        bad = 0;
        repeat (48) begin
            @(negedge mclk);
            bad = bad + ((out_leg[0].true_output_leg !== out_leg[1].true_output_leg) ? 1 : 0);
        end
        chk("sync_align", 0, bad);
    endtask : t_sync

    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        n_fail = 0;
        n_checks = 0;
        nrst = 1'b0;
        sync_in = 1'b0;
        pulse_request_in = 1'b1;
        ref_en = 1'b1;
        reg_wr = 1'b0;
        clr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        chan_cfg = '0;
        div_cfg = '0;
        gpio_en = '0;
        wsel = 0;
        repeat (20) @(negedge mclk);
        nrst = 1'b1;
        t_reset();
        t_regs();
        t_rates();
        t_static();
        t_replica();
        t_sync();
        tally_and_finish();
    end
endmodule : ocmd_tb_top
`default_nettype wire
